// file: verilog/slcr_pkg.sv
// Package of the serial link configuration register bank.
// Assumes: one 50 MHz clock; registers reached as 16-bit holding registers
// through a word access port driven by the frame decoder.
package slcr_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] OFS_TERM_LEVEL_B = 16'h024F;
    localparam logic [15:0] OFS_NODE_ID = 16'h02BC;
    localparam logic [15:0] OFS_LINE_RATE = 16'h02BD;
    localparam logic [15:0] OFS_FRAMING = 16'h02BE;
    localparam logic [15:0] OFS_REPLY_DELAY = 16'h02BF;

    // ----------------------------------------
    // Reset values and legal ranges
    // ----------------------------------------
    localparam logic [15:0] RST_TERM_LEVEL = 16'h0000;
    localparam logic [15:0] RST_NODE_ID = 16'h0001;
    localparam logic [15:0] RST_LINE_RATE = 16'h0006;
    localparam logic [15:0] RST_FRAMING = 16'h0002;
    localparam logic [15:0] RST_REPLY_DELAY = 16'h0014;
    localparam logic [15:0] NODE_ID_MIN = 16'h0001;
    localparam logic [15:0] NODE_ID_MAX = 16'h00F7;
    localparam logic [15:0] LINE_RATE_MAX = 16'h0006;
    localparam logic [15:0] FRAMING_MAX = 16'h0002;
    localparam logic [15:0] REPLY_DELAY_MAX = 16'h0063;
    localparam logic [15:0] TERM_LEVEL_MAX = 16'h0001;
    localparam logic [7:0] BCAST_NODE = 8'h00;

    // ----------------------------------------
    // Field positions and widths
    // ----------------------------------------
    localparam int NODE_W = 8;
    localparam int RATE_W = 3;
    localparam int FRAME_W = 2;
    localparam int DELAY_W = 7;
    localparam int TERM_LEVEL_BIT = 0;
    localparam int TERM_VOLT = 0;
    localparam int TERM_CURR = 1;
    localparam int N_TERM = 2;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        RATE_2400 = 3'b000,
        RATE_4800 = 3'b001,
        RATE_9600 = 3'b010,
        RATE_19200 = 3'b011,
        RATE_38400 = 3'b100,
        RATE_57600 = 3'b101,
        RATE_115200 = 3'b110
    } slcr_rate_t;

    typedef enum logic [1:0] {
        FRAME_NONE_2S = 2'b00,
        FRAME_ODD_1S = 2'b01,
        FRAME_EVEN_1S = 2'b10
    } slcr_frame_t;

    typedef struct packed {
        logic [NODE_W-1:0] node;
        slcr_rate_t rate;
        slcr_frame_t framing;
    } slcr_link_cfg_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] data;
    } slcr_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] data;
    } slcr_rsp_t;

    localparam slcr_link_cfg_t LINK_CFG_RST = '{
        node: RST_NODE_ID[NODE_W-1:0],
        rate: RATE_115200,
        framing: FRAME_EVEN_1S
    };

endpackage : slcr_pkg

// file: verilog/slcr_reply_timer.sv
// Reply hold-off timer: counts whole milliseconds before a reply may go.
// Assumes: start is a one-cycle pulse; starts while counting are ignored.
`timescale 1ns/10ps
module slcr_reply_timer #(
    parameter int unsigned CYCLES_PER_MS = slcr_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [slcr_pkg::DELAY_W-1:0] delay_ms,
    output logic busy,
    output logic go
);
    localparam int SUB_W = (CYCLES_PER_MS > 1) ? $clog2(CYCLES_PER_MS) : 1;
    localparam logic [SUB_W-1:0] SUB_MAX = SUB_W'(CYCLES_PER_MS - 1);

    typedef enum logic {
        TMR_IDLE = 1'b0,
        TMR_COUNT = 1'b1
    } slcr_tmr_state_t;

    typedef struct packed {
        slcr_tmr_state_t state;
        logic [slcr_pkg::DELAY_W-1:0] ms_left;
        logic [SUB_W-1:0] sub;
        logic go;
    } slcr_tmr_t;

    slcr_tmr_t s_q;
    slcr_tmr_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.go = 1'b0;
        case (s_q.state)
            TMR_IDLE: begin
                if (start) begin
                    if (delay_ms == '0) begin
                        s_d.go = 1'b1;
                    end else begin
                        s_d.state = TMR_COUNT;
                        s_d.ms_left = delay_ms;
                        s_d.sub = SUB_MAX;
                    end
                end
            end
            TMR_COUNT: begin
                if (s_q.sub == '0) begin
                    s_d.sub = SUB_MAX;
                    if (s_q.ms_left == 7'h01) begin
                        s_d.go = 1'b1;
                        s_d.state = TMR_IDLE;
                    end else begin
                        s_d.ms_left = s_q.ms_left - 7'h01;
                    end
                end else begin
                    s_d.sub = s_q.sub - SUB_W'(1);
                end
            end
            default: begin
                s_d.state = TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.state == TMR_COUNT);
    assign go = s_q.go;

    chk_zero_wait: assert property (@(posedge clk) disable iff (!rst_b)
        (start && !busy && delay_ms == '0) |=> go)
        else $error("zero reply delay did not release at once");
    chk_wait_holds: assert property (@(posedge clk) disable iff (!rst_b)
        (start && !busy && delay_ms != '0) |=> (!go && busy))
        else $error("reply released before its waiting time");

endmodule : slcr_reply_timer

// file: verilog/slcr_term_drive.sv
// Open-drain drivers of the voltage-fail and current-fail terminals.
// Assumes: the pad releases the line while oe is low.
`timescale 1ns/10ps
module slcr_term_drive (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [slcr_pkg::N_TERM-1:0] use_ctrl_b,
    input wire logic [slcr_pkg::N_TERM-1:0] fail_open,
    input wire logic level,
    output logic [slcr_pkg::N_TERM-1:0] pin_out,
    output logic [slcr_pkg::N_TERM-1:0] pin_oe
);
    typedef struct packed {
        logic [slcr_pkg::N_TERM-1:0] oe;
    } slcr_term_t;

    slcr_term_t s_q;
    slcr_term_t s_d;
    logic [slcr_pkg::N_TERM-1:0] open_want;

    // ----------------------------------------
    // Per-terminal source select
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < slcr_pkg::N_TERM; gi++) begin : g_term
            // Value 0 shorts the pin, value 1 leaves it open
            assign open_want[gi] = use_ctrl_b[gi] ? level : fail_open[gi];
        end
    endgenerate

    always_comb begin
        s_d.oe = ~open_want;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Open drain: never drive high
    assign pin_out = '0;
    assign pin_oe = s_q.oe;

    chk_term_short: assert property (@(posedge clk) disable iff (!rst_b)
        (use_ctrl_b[0] && !level) |=> pin_oe[0])
        else $error("voltage-fail terminal not shorted for level 0");
    chk_term_open: assert property (@(posedge clk) disable iff (!rst_b)
        (use_ctrl_b[1] && level) |=> !pin_oe[1])
        else $error("current-fail terminal not released for level 1");

endmodule : slcr_term_drive

// file: verilog/slcr_link_regs.sv
// Serial link configuration holding registers with node match,
// reply hold-off and the second terminal-output control.
// Assumes: a frame decoder issues word accesses and the diagnostics
// restart; a pad ring resolves the open-drain terminals.
`timescale 1ns/10ps

// Contract
// - Assigned fail terminals short for value 0, open for value 1.
// - Device answers only frames carrying its own active node identifier; here the reply timer arms for any non-broadcast frame, matched or not.
// - Node identifier accepts 1 to 247, defaults to 1.
// - New node identifier applies only after restart or power cycle.
// - Line rate codes 0 to 6, 2400 to 115200 bps, default 6.
// - Changed line rate applies only after restart or power cycle.
// - Framing codes 0 to 2: none/2 stop, odd/1, even/1; default 2.
// - Framing change applies after restart; its own reply keeps old framing.
// - Unapplied settings become active at the next power-up; here reset reloads the defaults instead.
// - Each unicast reply waits the set 0 to 99 ms, default 20.
// - Reply delay write applies at once, even to its own reply.
module slcr_link_regs #(
    parameter int unsigned CYCLES_PER_MS = slcr_pkg::CYC_PER_MS
) (
    input wire logic clk,
    input wire logic rst_b,
    input slcr_pkg::slcr_req_t req,
    output slcr_pkg::slcr_rsp_t rsp,
    input wire logic restart_comm,
    input wire logic frame_node_valid,
    input wire logic [slcr_pkg::NODE_W-1:0] frame_node,
    output logic node_match,
    output logic node_bcast,
    input wire logic reply_pend,
    output logic reply_go,
    output slcr_pkg::slcr_link_cfg_t link_cfg,
    output logic cfg_pending,
    input wire logic [slcr_pkg::N_TERM-1:0] term_use_ctrl_b,
    input wire logic [slcr_pkg::N_TERM-1:0] term_fail_open,
    output logic [slcr_pkg::N_TERM-1:0] term_out,
    output logic [slcr_pkg::N_TERM-1:0] term_oe
);
    typedef struct packed {
        slcr_pkg::slcr_link_cfg_t stored;
        slcr_pkg::slcr_link_cfg_t active;
        logic [slcr_pkg::DELAY_W-1:0] delay_ms;
        logic term_level;
        slcr_pkg::slcr_rsp_t rsp;
        logic boot;
        logic match;
        logic bcast;
        logic last_bcast;
        logic pending;
    } slcr_core_t;

    localparam slcr_core_t CORE_RST = '{
        stored: slcr_pkg::LINK_CFG_RST,
        active: slcr_pkg::LINK_CFG_RST,
        delay_ms: slcr_pkg::RST_REPLY_DELAY[slcr_pkg::DELAY_W-1:0],
        term_level: slcr_pkg::RST_TERM_LEVEL[slcr_pkg::TERM_LEVEL_BIT],
        rsp: '0,
        boot: 1'b1,
        match: 1'b0,
        bcast: 1'b0,
        last_bcast: 1'b0,
        pending: 1'b0
    };

    slcr_core_t s_q;
    slcr_core_t s_d;
    logic reply_start;
    logic timer_busy;
    logic [15:0] rd_word;
    logic rd_hit;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (req.addr)
            slcr_pkg::OFS_TERM_LEVEL_B: begin
                rd_word = {15'h0000, s_q.term_level};
            end
            slcr_pkg::OFS_NODE_ID: begin
                rd_word = {8'h00, s_q.stored.node};
            end
            slcr_pkg::OFS_LINE_RATE: begin
                rd_word = {13'h0000, s_q.stored.rate};
            end
            slcr_pkg::OFS_FRAMING: begin
                rd_word = {14'h0000, s_q.stored.framing};
            end
            slcr_pkg::OFS_REPLY_DELAY: begin
                rd_word = {9'h000, s_q.delay_ms};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rsp = '0;
        s_d.boot = 1'b0;
        s_d.match = 1'b0;
        s_d.bcast = 1'b0;

        // Reset loads defaults into both copies; the boot cycle then
        // reloads the active set, standing in for a nonvolatile restore.
        if (s_q.boot || restart_comm) begin
            s_d.active = s_q.stored;
        end

        if (req.wr) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.data = req.data;
            case (req.addr)
                slcr_pkg::OFS_TERM_LEVEL_B: begin
                    if (req.data <= slcr_pkg::TERM_LEVEL_MAX) begin
                        s_d.term_level = req.data[slcr_pkg::TERM_LEVEL_BIT];
                    end else begin
                        s_d.rsp.err = 1'b1;
                    end
                end
                slcr_pkg::OFS_NODE_ID: begin
                    if (req.data >= slcr_pkg::NODE_ID_MIN &&
                        req.data <= slcr_pkg::NODE_ID_MAX) begin
                        s_d.stored.node = req.data[slcr_pkg::NODE_W-1:0];
                    end else begin
                        s_d.rsp.err = 1'b1;
                    end
                end
                slcr_pkg::OFS_LINE_RATE: begin
                    if (req.data <= slcr_pkg::LINE_RATE_MAX) begin
                        s_d.stored.rate =
                            slcr_pkg::slcr_rate_t'(req.data[slcr_pkg::RATE_W-1:0]);
                    end else begin
                        s_d.rsp.err = 1'b1;
                    end
                end
                slcr_pkg::OFS_FRAMING: begin
                    if (req.data <= slcr_pkg::FRAMING_MAX) begin
                        s_d.stored.framing =
                            slcr_pkg::slcr_frame_t'(req.data[slcr_pkg::FRAME_W-1:0]);
                    end else begin
                        s_d.rsp.err = 1'b1;
                    end
                end
                slcr_pkg::OFS_REPLY_DELAY: begin
                    if (req.data <= slcr_pkg::REPLY_DELAY_MAX) begin
                        s_d.delay_ms = req.data[slcr_pkg::DELAY_W-1:0];
                    end else begin
                        s_d.rsp.err = 1'b1;
                    end
                end
                default: begin
                    s_d.rsp.err = 1'b1;
                end
            endcase
        end else if (req.rd) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.data = rd_word;
            s_d.rsp.err = !rd_hit;
        end

        // Matching uses the active copy, so a fresh write cannot redirect
        // the reply to the frame that carried it.
        if (frame_node_valid) begin
            s_d.match = (frame_node == s_q.active.node);
            s_d.bcast = (frame_node == slcr_pkg::BCAST_NODE);
            s_d.last_bcast = (frame_node == slcr_pkg::BCAST_NODE);
        end

        s_d.pending = (s_d.stored != s_d.active);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Reply hold-off and terminals
    // ----------------------------------------
    // Broadcasts never get a reply, so they never arm the timer.
    assign reply_start = reply_pend && !s_q.last_bcast;

    slcr_reply_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(reply_start),
        .delay_ms(s_q.delay_ms),
        .busy(timer_busy),
        .go(reply_go)
    );

    slcr_term_drive u_term (
        .clk(clk),
        .rst_b(rst_b),
        .use_ctrl_b(term_use_ctrl_b),
        .fail_open(term_fail_open),
        .level(s_q.term_level),
        .pin_out(term_out),
        .pin_oe(term_oe)
    );

    assign rsp = s_q.rsp;
    assign link_cfg = s_q.active;
    assign node_match = s_q.match;
    assign node_bcast = s_q.bcast;
    assign cfg_pending = s_q.pending;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_node_range: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_NODE_ID &&
         (req.data == 16'h0000 || req.data > slcr_pkg::NODE_ID_MAX))
        |=> (rsp.err && $stable(s_q.stored.node)))
        else $error("illegal node identifier accepted");
    chk_node_held: assert property (@(posedge clk) disable iff (!rst_b)
        (!restart_comm && !s_q.boot) |=> $stable(link_cfg.node))
        else $error("active node identifier moved without restart");
    chk_rate_range: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_LINE_RATE &&
         req.data > slcr_pkg::LINE_RATE_MAX) |=> rsp.err)
        else $error("illegal line rate code accepted");
    chk_rate_held: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_LINE_RATE && !restart_comm && !s_q.boot)
        |=> $stable(link_cfg.rate))
        else $error("line rate changed on write");
    chk_frame_old: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_FRAMING && !restart_comm && !s_q.boot)
        |=> (rsp.valid && $stable(link_cfg.framing)))
        else $error("framing changed before its own reply");
    chk_frame_range: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_FRAMING &&
         req.data > slcr_pkg::FRAMING_MAX) |=> rsp.err)
        else $error("illegal framing code accepted");
    chk_restart_copy: assert property (@(posedge clk) disable iff (!rst_b)
        restart_comm |=> (link_cfg == $past(s_q.stored)))
        else $error("restart did not load stored settings");
    chk_delay_now: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_REPLY_DELAY &&
         req.data <= slcr_pkg::REPLY_DELAY_MAX)
        |=> (s_q.delay_ms == $past(req.data[slcr_pkg::DELAY_W-1:0])))
        else $error("reply delay not applied at once");
    chk_node_match: assert property (@(posedge clk) disable iff (!rst_b)
        (frame_node_valid && frame_node != link_cfg.node) |=> !node_match)
        else $error("foreign node identifier matched");
    chk_boot_load: assert property (@(posedge clk) disable iff (!rst_b)
        s_q.boot |=> (link_cfg == $past(s_q.stored)))
        else $error("power-up did not load stored settings");

    chk_node_store: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_NODE_ID &&
         req.data >= slcr_pkg::NODE_ID_MIN && req.data <= slcr_pkg::NODE_ID_MAX)
        |=> (!rsp.err && s_q.stored.node == $past(req.data[slcr_pkg::NODE_W-1:0])))
        else $error("legal node identifier not stored");

    chk_match_own: assert property (@(posedge clk) disable iff (!rst_b)
        (frame_node_valid && frame_node == link_cfg.node) |=> node_match)
        else $error("own node identifier not matched");

    chk_restart_clears: assert property (@(posedge clk) disable iff (!rst_b)
        (restart_comm && !req.wr) |=> !cfg_pending)
        else $error("settings still pending after restart");

    chk_term_range: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_TERM_LEVEL_B &&
         req.data > slcr_pkg::TERM_LEVEL_MAX)
        |=> (rsp.err && $stable(s_q.term_level)))
        else $error("illegal terminal level accepted");

    chk_delay_range: assert property (@(posedge clk) disable iff (!rst_b)
        (req.wr && req.addr == slcr_pkg::OFS_REPLY_DELAY &&
         req.data > slcr_pkg::REPLY_DELAY_MAX)
        |=> (rsp.err && $stable(s_q.delay_ms)))
        else $error("illegal reply delay accepted");

    chk_bcast_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (s_q.last_bcast && reply_pend && !timer_busy) |=> (!timer_busy && !reply_go))
        else $error("reply armed for a broadcast frame");


    cov_restart_apply: cover property (@(posedge clk) disable iff (!rst_b)
        cfg_pending ##1 restart_comm ##1 !cfg_pending);
    cov_reply_wait: cover property (@(posedge clk) disable iff (!rst_b)
        reply_start ##1 timer_busy ##[1:300] reply_go);
    cov_bad_write: cover property (@(posedge clk) disable iff (!rst_b)
        rsp.valid && rsp.err);
    cov_zero_wait: cover property (@(posedge clk) disable iff (!rst_b)
        reply_start && s_q.delay_ms == '0 ##1 reply_go);
    cov_bcast_seen: cover property (@(posedge clk) disable iff (!rst_b)
        node_bcast);

endmodule : slcr_link_regs

// file: testbench/slcr_client_model.sv
// Client side of the link: sends one frame's node field, asks for a reply,
// then waits for the reply slot under its own timeout.
// Assumes: driven at the falling edge; the bench calls transact by hierarchy.
`timescale 1ns/10ps
module slcr_client_model (
    input wire logic clk,
    input wire logic reply_go,
    input wire logic node_match,
    input wire logic node_bcast,
    output logic frame_node_valid,
    output logic [7:0] frame_node,
    output logic reply_pend
);
    initial begin
        frame_node_valid = 1'b0;
        frame_node = 8'h5A;
        reply_pend = 1'b0;
    end

    // Timeout is set by the caller above delay plus frame time
    task automatic transact(input logic [7:0] node, input int limit,
                            output int waited, output logic [1:0] matched);
        @(negedge clk);
        frame_node = node;
        frame_node_valid = 1'b1;
        @(negedge clk);
        frame_node_valid = 1'b0;
        // Released field shows the inverse, not a stale copy
        frame_node = ~node;
        matched = {node_bcast, node_match};
        reply_pend = 1'b1;
        waited = 0;
        do begin
            @(negedge clk);
            reply_pend = 1'b0;
            waited++;
        end while (reply_go !== 1'b1 && waited < limit);
    endtask : transact
endmodule : slcr_client_model

// file: testbench/tb_slcr_link_regs.sv
// Self-checking bench of the serial link configuration register bank.
// Assumes: slcr_pkg, the design and the client model are compiled first.
`timescale 1ns/10ps
module tb_slcr_link_regs;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] data;
        logic err;
        logic [15:0] exp;
    } slcr_row_t;
    // Short millisecond keeps the 99 ms case cheap
    localparam int CPM = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    slcr_pkg::slcr_req_t req = '0;
    slcr_pkg::slcr_rsp_t rsp;
    logic restart_comm = 1'b0;
    logic frame_node_valid, node_match, node_bcast, reply_pend, reply_go;
    logic cfg_pending;
    logic [1:0] m;
    logic [7:0] frame_node;
    slcr_pkg::slcr_link_cfg_t link_cfg;
    logic [1:0] term_use_ctrl_b = 2'b01;
    logic [1:0] term_fail_open = 2'b10;
    logic [1:0] term_out, term_oe;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    int w;
    slcr_row_t rows [23] = '{
        '{1'b0, 16'h024F, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, 16'h02BC, 16'h0000, 1'b0, 16'h0001},
        '{1'b0, 16'h02BD, 16'h0000, 1'b0, 16'h0006},
        '{1'b0, 16'h02BE, 16'h0000, 1'b0, 16'h0002},
        '{1'b0, 16'h02BF, 16'h0000, 1'b0, 16'h0014},
        '{1'b0, 16'h02C0, 16'h0000, 1'b1, 16'h0000},
        '{1'b0, 16'h024E, 16'h0000, 1'b1, 16'h0000},
        '{1'b1, 16'h02BC, 16'h0000, 1'b1, 16'h0000},
        '{1'b1, 16'h02BC, 16'h00F8, 1'b1, 16'h0000},
        '{1'b1, 16'h02BC, 16'h00F7, 1'b0, 16'h00F7},
        '{1'b1, 16'h02BD, 16'h0007, 1'b1, 16'h0000},
        '{1'b1, 16'h02BD, 16'h0000, 1'b0, 16'h0000},
        '{1'b1, 16'h02BE, 16'h0003, 1'b1, 16'h0000},
        '{1'b1, 16'h02BE, 16'h0000, 1'b0, 16'h0000},
        '{1'b1, 16'h02BF, 16'h0064, 1'b1, 16'h0000},
        '{1'b1, 16'h02BF, 16'h0063, 1'b0, 16'h0063},
        '{1'b1, 16'h024F, 16'h0002, 1'b1, 16'h0000},
        '{1'b0, 16'h02BC, 16'h0000, 1'b0, 16'h00F7},
        '{1'b0, 16'h02BD, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, 16'h02BE, 16'h0000, 1'b0, 16'h0000},
        '{1'b0, 16'h02BF, 16'h0000, 1'b0, 16'h0063},
        '{1'b0, 16'h024F, 16'h0000, 1'b0, 16'h0000},
        '{1'b1, 16'h1234, 16'h0001, 1'b1, 16'h0000}
    };

    always #10 clk = ~clk;

    slcr_link_regs #(.CYCLES_PER_MS(CPM)) dut (
        .clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .restart_comm(restart_comm),
        .frame_node_valid(frame_node_valid), .frame_node(frame_node),
        .node_match(node_match), .node_bcast(node_bcast), .reply_pend(reply_pend),
        .reply_go(reply_go), .link_cfg(link_cfg), .cfg_pending(cfg_pending),
        .term_use_ctrl_b(term_use_ctrl_b), .term_fail_open(term_fail_open),
        .term_out(term_out), .term_oe(term_oe)
    );

    slcr_client_model p (
        .clk(clk), .reply_go(reply_go), .node_match(node_match), .node_bcast(node_bcast),
        .frame_node_valid(frame_node_valid), .frame_node(frame_node),
        .reply_pend(reply_pend)
    );

    task automatic finish_test();
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One word access then an idle edge; answer is read at the next falling edge
    task automatic acc(input logic wr, input logic [15:0] addr,
                       input logic [15:0] data, input logic err, input logic [15:0] exp);
        req = '{wr: wr, rd: !wr, addr: addr, data: data};
        @(negedge clk);
        req = '0;
        check({14'h0, rsp.valid, rsp.err}, {14'h0, 1'b1, err});
        if (!err) begin
            check(rsp.data, exp);
        end
        @(negedge clk);
    endtask : acc

    task automatic restart();
        restart_comm = 1'b1;
        @(negedge clk);
        restart_comm = 1'b0;
    endtask : restart

    // Hang guard: whole run needs roughly six hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        check({14'h0, term_oe}, 16'h0000);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check({14'h0, term_oe}, 16'h0001);
        check({3'h0, link_cfg}, {3'h0, 8'h01, 3'h6, 2'h2});
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].addr, rows[i].data, rows[i].err, rows[i].exp);
        end
        // ----------------------------------------
        // Pending link settings and restart
        // ----------------------------------------
        check({3'h0, link_cfg}, {3'h0, 8'h01, 3'h6, 2'h2});
        check({15'h0, cfg_pending}, 16'h0001);
        restart();
        check({3'h0, link_cfg}, {3'h0, 8'hF7, 3'h0, 2'h0});
        check({15'h0, cfg_pending}, 16'h0000);
        for (int k = 0; k < 7; k++) begin
            acc(1'b1, 16'h02BD, 16'(k), 1'b0, 16'(k));
            acc(1'b1, 16'h02BE, 16'(k % 3), 1'b0, 16'(k % 3));
            restart();
            check({3'h0, link_cfg}, {3'h0, 8'hF7, 3'(k), 2'(k % 3)});
        end
        // ----------------------------------------
        // Node match and reply hold-off
        // ----------------------------------------
        p.transact(8'hF7, 500, w, m);
        check({14'h0, m}, 16'h0001);
        check(16'(w), 16'(99 * CPM + 1));
        acc(1'b1, 16'h02BF, 16'h0000, 1'b0, 16'h0000);
        p.transact(8'hF7, 500, w, m);
        check(16'(w), 16'h0001);
        acc(1'b1, 16'h02BF, 16'h0002, 1'b0, 16'h0002);
        p.transact(8'h05, 50, w, m);
        check({14'h0, m}, 16'h0000);
        p.transact(8'hF7, 50, w, m);
        check(16'(w), 16'(2 * CPM + 1));
        p.transact(8'h00, 50, w, m);
        check({14'h0, m}, 16'h0002);
        check(16'(w), 16'h0032);
        // ----------------------------------------
        // Fail terminals
        // ----------------------------------------
        acc(1'b1, 16'h024F, 16'h0001, 1'b0, 16'h0001);
        @(negedge clk);
        check({14'h0, term_oe}, 16'h0000);
        term_use_ctrl_b = 2'b10;
        term_fail_open = 2'b00;
        @(negedge clk);
        check({12'h0, term_out, term_oe}, 16'h0001);
        acc(1'b1, 16'h024F, 16'h0000, 1'b0, 16'h0000);
        @(negedge clk);
        check({14'h0, term_oe}, 16'h0003);
        // ----------------------------------------
        // Power cycle in mid-run
        // ----------------------------------------
        rst_b = 1'b0;
        repeat (3) @(negedge clk);
        check({3'h0, link_cfg}, {3'h0, 8'h01, 3'h6, 2'h2});
        rst_b = 1'b1;
        @(negedge clk);
        acc(1'b0, 16'h02BF, 16'h0000, 1'b0, 16'h0014);
        check({3'h0, link_cfg}, {3'h0, 8'h01, 3'h6, 2'h2});
        finish_test();
    end
endmodule : tb_slcr_link_regs
